//--- design/dxc_ctrl.sv
// external frequency/phase steering, offset summation and lock detection
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module dxc_ctrl
	import dxc_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// step pins
	input wire logic gpio_inc,
	input wire logic gpio_dec,
	// loop side
	input wire logic [PW_W-1:0] phase_error,
	input wire logic [1:0] ref_sel,
	// outputs to divider and loop filter, holdover and lock status
	output logic [NOSC-1:0][FW_W-1:0] frequency_word,
	output logic divider_bypass,
	output logic [PW_W-1:0] filter_drive,
	output logic [PW_W-1:0] snap_offset,
	output logic snap_strobe,
	output logic holdover,
	output logic lock_int,
	output logic lock
);

//------------------------------------------------------------------------------
// bus slave
//------------------------------------------------------------------------------
	logic aw_hold_q;
	logic w_hold_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_do;
	logic [31:0] rd_c;
	logic rd_err_c;
	logic wr_err_c;

	assign wr_do = aw_hold_q & w_hold_q & ~bvalid;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			awready <= 1'b1;
			awaddr_q <= '0;
		end
		else if (awvalid && awready)
		begin
			aw_hold_q <= 1'b1;
			awready <= 1'b0;
			awaddr_q <= awaddr;
		end
		else if (wr_do)
		begin
			aw_hold_q <= 1'b0;
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_hold_q <= 1'b0;
			wready <= 1'b1;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else if (wvalid && wready)
		begin
			w_hold_q <= 1'b1;
			wready <= 1'b0;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end
		else if (wr_do)
		begin
			w_hold_q <= 1'b0;
			wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end
		else if (wr_do)
		begin
			bvalid <= 1'b1;
			bresp <= wr_err_c ? RESP_SLVERR : RESP_OKAY;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_c;
			rresp <= rd_err_c ? RESP_SLVERR : RESP_OKAY;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

//------------------------------------------------------------------------------
// configuration registers
//------------------------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic [NOSC-1:0][31:0] step_q;
	logic [NOSC-1:0][31:0] flo_q;
	logic [NOSC-1:0][FW_W-1:0] fw_q;
	logic [PW_W-1:0] phase_q;
	logic [TMR_W-1:0] ptime_q;
	logic [PW_W-1:0] ch_off_q;
	logic [NIN-1:0][PW_W-1:0] in_off_q;
	logic [31:0] lock_win_q;
	logic [15:0] lock_time_q;
	logic [15:0] slope_q;
	logic tmr_run_q;
	dxc_mode_t mode;

	assign mode = dxc_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);

	function automatic logic hit(input logic [ADDR_W-1:0] ofs);
		return wr_do && awaddr_q == ofs;
	endfunction

	always_comb
	begin
		rd_c = '0;
		rd_err_c = 1'b0;
		case (araddr)
			OFS_CTRL: rd_c = ctrl_q;
			OFS_STATUS: rd_c = {28'h000_0000, tmr_run_q, holdover, lock_int, lock};
			OFS_FREQ_LO0: rd_c = fw_q[0][31:0];
			OFS_FREQ_HI0: rd_c = {{22{fw_q[0][FW_W-1]}}, fw_q[0][FW_W-1:32]};
			OFS_FREQ_LO1: rd_c = fw_q[1][31:0];
			OFS_FREQ_HI1: rd_c = {{22{fw_q[1][FW_W-1]}}, fw_q[1][FW_W-1:32]};
			OFS_STEP0: rd_c = step_q[0];
			OFS_STEP1: rd_c = step_q[1];
			OFS_STEP_CMD: rd_c = '0;
			OFS_PHASE: rd_c = phase_q;
			OFS_PTIMER: rd_c = {16'h0000, ptime_q};
			OFS_CH_OFF: rd_c = ch_off_q;
			OFS_IN_OFF0, 7'h34, 7'h38, 7'h3C: rd_c = in_off_q[araddr[3:2]];
			OFS_LOCK_WIN: rd_c = lock_win_q;
			OFS_LOCK_TIME: rd_c = {16'h0000, lock_time_q};
			OFS_SLOPE: rd_c = {16'h0000, slope_q};
			default: rd_err_c = 1'b1;
		endcase
	end

	assign wr_err_c = awaddr_q[1:0] != 2'h0 || awaddr_q > OFS_SLOPE;

	logic [31:0] ptime_m;
	logic [31:0] ltime_m;
	logic [31:0] slope_m;

	// 16-bit fields merged through a full word, then cut back
	assign ptime_m = merge({16'h0000, ptime_q}, wdata_q, wstrb_q);
	assign ltime_m = merge({16'h0000, lock_time_q}, wdata_q, wstrb_q);
	assign slope_m = merge({16'h0000, slope_q}, wdata_q, wstrb_q);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q <= CTRL_RST;
			ptime_q <= '0;
			ch_off_q <= '0;
			lock_win_q <= '0;
			lock_time_q <= '0;
			slope_q <= '0;
		end
		else
		begin
			if (hit(OFS_CTRL))
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
			if (hit(OFS_PTIMER))
				ptime_q <= ptime_m[15:0];
			if (hit(OFS_CH_OFF))
				ch_off_q <= merge(ch_off_q, wdata_q, wstrb_q);
			if (hit(OFS_LOCK_WIN))
				lock_win_q <= merge(lock_win_q, wdata_q, wstrb_q);
			if (hit(OFS_LOCK_TIME))
				lock_time_q <= ltime_m[15:0];
			if (hit(OFS_SLOPE))
				slope_q <= slope_m[15:0];
		end
	end

	for (genvar i = 0; i < NIN; i++)
	begin : g_in
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				in_off_q[i] <= '0;
			else if (hit(OFS_IN_OFF0 + 7'(i * 4)))
				in_off_q[i] <= merge(in_off_q[i], wdata_q, wstrb_q);
		end
	end

//------------------------------------------------------------------------------
// millisecond tick and step pins
//------------------------------------------------------------------------------
	logic [17:0] ms_cnt_q;
	logic ms_tick;
	logic [2:0] inc_s_q;
	logic [2:0] dec_s_q;
	logic pin_inc;
	logic pin_dec;
	logic step_wr;

	// a plain net, so the step strobe follows the write qualifier itself
	assign step_wr = wr_do && awaddr_q == OFS_STEP_CMD;
	assign ms_tick = ms_cnt_q == 18'(MS_CYCLES - 1);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ms_cnt_q <= '0;
		else
			ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 18'h0_0001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			inc_s_q <= '0;
			dec_s_q <= '0;
		end
		else
		begin
			inc_s_q <= {inc_s_q[1:0], gpio_inc};
			dec_s_q <= {dec_s_q[1:0], gpio_dec};
		end
	end

	assign pin_inc = inc_s_q[1] & ~inc_s_q[2] & ctrl_q[CTRL_GPIO_EN];
	assign pin_dec = dec_s_q[1] & ~dec_s_q[2] & ctrl_q[CTRL_GPIO_EN];

//------------------------------------------------------------------------------
// frequency words per oscillator
//------------------------------------------------------------------------------
	for (genvar i = 0; i < NOSC; i++)
	begin : g_osc
		logic cmd_inc;
		logic cmd_dec;
		logic pin_sel;
		logic up;
		logic dn;
		logic signed [FW_W:0] sum;
		logic [FW_W-1:0] fw_hi;
		logic [31:0] hi_m;

		assign cmd_inc = step_wr && wstrb_q[0] && wdata_q[i];
		assign cmd_dec = step_wr && wstrb_q[1] && wdata_q[CMD_DEC_LSB + i];
		assign pin_sel = ctrl_q[CTRL_GPIO_OSC] == 1'(i);
		assign up = cmd_inc | (pin_inc & pin_sel);
		assign dn = cmd_dec | (pin_dec & pin_sel);
		// only the low 42 bits of the sign-extended word are kept
		assign hi_m = merge({{22{fw_q[i][FW_W-1]}}, fw_q[i][FW_W-1:32]}, wdata_q, wstrb_q);
		assign fw_hi = {hi_m[9:0], flo_q[i]};
		// offset is added as an unsigned magnitude
		assign sum = up ? $signed({fw_q[i][FW_W-1], fw_q[i]}) + $signed({11'h000, step_q[i]})
			: $signed({fw_q[i][FW_W-1], fw_q[i]}) - $signed({11'h000, step_q[i]});

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				step_q[i] <= '0;
				flo_q[i] <= '0;
			end
			else
			begin
				if (hit(OFS_STEP0 + 7'(i * 4)))
					step_q[i] <= merge(step_q[i], wdata_q, wstrb_q);
				if (hit(OFS_FREQ_LO0 + 7'(i * 8)))
					flo_q[i] <= merge(flo_q[i], wdata_q, wstrb_q);
			end
		end

		// the low word only stages; the high word commits both at once
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				fw_q[i] <= '0;
			else if (hit(OFS_FREQ_HI0 + 7'(i * 8)))
				fw_q[i] <= fw_hi;
			else if (up ^ dn)
			begin
				if (sum[FW_W] != sum[FW_W-1])
					fw_q[i] <= sum[FW_W] ? FW_MIN : FW_MAX;
				else
					fw_q[i] <= sum[FW_W-1:0];
			end
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				frequency_word[i] <= '0;
			else
				frequency_word[i] <= fw_q[i];
		end
	end

//------------------------------------------------------------------------------
// phase word and its expiry timer
//------------------------------------------------------------------------------
	logic [TMR_W-1:0] tmr_q;
	logic expire;

	assign expire = tmr_run_q && ms_tick && tmr_q == 16'h0001;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tmr_q <= '0;
			tmr_run_q <= 1'b0;
		end
		else if (hit(OFS_PHASE))
		begin
			tmr_q <= ptime_q;
			tmr_run_q <= ctrl_q[CTRL_TMR_EN] && ptime_q != '0;
		end
		else if (expire)
			tmr_run_q <= 1'b0;
		else if (tmr_run_q && ms_tick)
			tmr_q <= tmr_q - 16'h0001;
	end

	// a fresh phase word beats a simultaneous expiry here, but not in the holdover flag below
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			phase_q <= '0;
		else if (hit(OFS_PHASE))
			phase_q <= merge(phase_q, wdata_q, wstrb_q);
		else if (expire && !ctrl_q[CTRL_EXP_HOLD])
			phase_q <= '0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			holdover <= 1'b0;
		else if (expire && ctrl_q[CTRL_EXP_HOLD])
			holdover <= 1'b1;
		else if (hit(OFS_PHASE))
			holdover <= 1'b0;
	end

//------------------------------------------------------------------------------
// slope-limited phase target and loop filter drive
//------------------------------------------------------------------------------
	logic [PW_W-1:0] applied_q;
	logic [23:0] budget_q;
	logic [24:0] budget_add;
	logic step_ok;
	logic signed [PW_W+1:0] drive_sum;
	logic [PW_W-1:0] drive_c;
	logic [1:0] ref_q;

	// budget in ps, refilled each ms by the cap in ns/s plus one (one ps per ms)
	assign budget_add = {1'b0, budget_q} + (ms_tick ? {9'h000, slope_q} + 25'h00_0001 : '0);
	assign step_ok = budget_q >= PS_PER_LSB;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			budget_q <= '0;
		else if (budget_add[24])
			budget_q <= BUDGET_MAX;
		else if (applied_q != phase_q && step_ok)
			budget_q <= budget_add[23:0] - PS_PER_LSB;
		else
			budget_q <= budget_add[23:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			applied_q <= '0;
		else if (!ctrl_q[CTRL_SLOPE_EN])
			applied_q <= phase_q;
		else if (applied_q != phase_q && step_ok)
			applied_q <= $signed(phase_q) > $signed(applied_q) ? applied_q + 32'h0000_0001
				: applied_q - 32'h0000_0001;
	end

	always_comb
	begin
		drive_sum = '0;
		case (mode)
			MODE_PHASE: drive_sum = $signed({{2{applied_q[PW_W-1]}}, applied_q});
			MODE_CLOSED: drive_sum = $signed({{2{phase_error[PW_W-1]}}, phase_error})
				+ $signed({{2{in_off_q[ref_sel][PW_W-1]}}, in_off_q[ref_sel]})
				+ $signed({{2{ch_off_q[PW_W-1]}}, ch_off_q});
			default: drive_sum = '0;
		endcase
		if (drive_sum > $signed(34'h0_7FFF_FFFF))
			drive_c = 32'h7FFF_FFFF;
		else if (drive_sum < $signed(34'h3_8000_0000))
			drive_c = 32'h8000_0000;
		else
			drive_c = drive_sum[PW_W-1:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			filter_drive <= '0;
			divider_bypass <= 1'b1;
			ref_q <= '0;
			snap_offset <= '0;
			snap_strobe <= 1'b0;
		end
		else
		begin
			filter_drive <= drive_c;
			divider_bypass <= mode == MODE_FREQ;
			ref_q <= ref_sel;
			snap_offset <= in_off_q[ref_sel] + ch_off_q;
			// an offset write or a reference change jumps the phase once
			snap_strobe <= hit(OFS_CH_OFF) || ref_q != ref_sel
				|| (wr_do && awaddr_q[6:4] == 3'h3);
		end
	end

//------------------------------------------------------------------------------
// lock detector
//------------------------------------------------------------------------------
	logic [PW_W-1:0] err_abs;
	logic [15:0] lk_cnt_q;

	assign err_abs = phase_error[PW_W-1] ? 32'h0000_0000 - phase_error : phase_error;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lk_cnt_q <= '0;
		else if (err_abs > lock_win_q)
			lk_cnt_q <= '0;
		else if (ms_tick && lk_cnt_q != 16'hFFFF)
			lk_cnt_q <= lk_cnt_q + 16'h0001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lock <= 1'b0;
			lock_int <= 1'b0;
		end
		else
		begin
			lock <= err_abs <= lock_win_q && lk_cnt_q >= lock_time_q;
			lock_int <= err_abs <= lock_win_q && lk_cnt_q >= {1'b0, lock_time_q[15:1]};
		end
	end

endmodule

//--- design/dxc_pkg.sv
// constants and types for the external oscillator-steering and lock-detect block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package dxc_pkg;

	localparam int NOSC = 2;
	localparam int NIN = 4;
	localparam int ADDR_W = 7;
	localparam int FW_W = 42;
	localparam int FW_REG_W = 48;
	localparam int PW_W = 32;
	localparam int CMD_W = 16;
	localparam int TMR_W = 16;

	// register byte addresses
	localparam logic [ADDR_W-1:0] OFS_CTRL = 7'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 7'h04;
	localparam logic [ADDR_W-1:0] OFS_FREQ_LO0 = 7'h08;
	localparam logic [ADDR_W-1:0] OFS_FREQ_HI0 = 7'h0C;
	localparam logic [ADDR_W-1:0] OFS_FREQ_LO1 = 7'h10;
	localparam logic [ADDR_W-1:0] OFS_FREQ_HI1 = 7'h14;
	localparam logic [ADDR_W-1:0] OFS_STEP0 = 7'h18;
	localparam logic [ADDR_W-1:0] OFS_STEP1 = 7'h1C;
	localparam logic [ADDR_W-1:0] OFS_STEP_CMD = 7'h20;
	localparam logic [ADDR_W-1:0] OFS_PHASE = 7'h24;
	localparam logic [ADDR_W-1:0] OFS_PTIMER = 7'h28;
	localparam logic [ADDR_W-1:0] OFS_CH_OFF = 7'h2C;
	localparam logic [ADDR_W-1:0] OFS_IN_OFF0 = 7'h30;
	localparam logic [ADDR_W-1:0] OFS_LOCK_WIN = 7'h40;
	localparam logic [ADDR_W-1:0] OFS_LOCK_TIME = 7'h44;
	localparam logic [ADDR_W-1:0] OFS_SLOPE = 7'h48;

	// control register fields and the step command's decrement bit offset
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_TMR_EN = 2;
	localparam int CTRL_EXP_HOLD = 3;
	localparam int CTRL_SLOPE_EN = 4;
	localparam int CTRL_GPIO_EN = 5;
	localparam int CTRL_GPIO_OSC = 6;
	localparam int CMD_DEC_LSB = 8;

	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [FW_W-1:0] FW_MAX = 42'h1FF_FFFF_FFFF;
	localparam logic [FW_W-1:0] FW_MIN = 42'h200_0000_0000;

	localparam int CLK_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam logic [23:0] PS_PER_LSB = 24'h00_0032;
	localparam logic [23:0] BUDGET_MAX = 24'hFF_FFFF;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {MODE_FREQ, MODE_PHASE, MODE_CLOSED} dxc_mode_t;

endpackage

//--- sim/dxc_ctrl_assertions.sv
// port-level timing checks for the steering block
`timescale 1ns/100ps
module dxc_ctrl_assertions
	import dxc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// steering and lock
	input wire logic [1:0] ref_sel,
	input wire logic [NOSC-1:0][FW_W-1:0] frequency_word,
	input wire logic snap_strobe,
	input wire logic lock_int,
	input wire logic lock
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence lo_taken;
		wr_taken ##0 awaddr == OFS_FREQ_LO0;
	endsequence

	wr_answer_a: assert property (wr_taken |-> ##[1:3] bvalid)
		else $error("write response late");
	aw_refuse_a: assert property (wr_taken |=> !awready && !wready)
		else $error("write channels open before write done");
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer not one cycle after address");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	lo_stage_a: assert property (lo_taken |=> $stable(frequency_word[0]) [*3])
		else $error("low half alone changed the word");
	lock_order_a: assert property (lock |-> lock_int)
		else $error("lock without internal lock");
	snap_ref_a: assert property ($changed(ref_sel) |-> ##[0:2] snap_strobe)
		else $error("no phase snap on reference change");
endmodule

//--- sim/dxc_ctrl_test.sv
// self-checking bench for the steering and lock-detect block
`timescale 1ns/100ps
module dxc_ctrl_test
	import dxc_pkg::*;
;
	localparam int MSC = 50;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, gpio_inc, gpio_dec;
	logic divider_bypass, snap_strobe, holdover, lock_int, lock;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, choff, p, d, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, ref_sel, r;
	logic [PW_W-1:0] phase_error, filter_drive, snap_offset;
	logic [NOSC-1:0][FW_W-1:0] frequency_word;
	logic [FW_W-1:0] fw [NOSC] = '{42'h0, 42'h0};
	logic [31:0] stp [NOSC];
	logic [31:0] inoff [NIN];
	logic [63:0] rr;
	logic [15:0] cmds [5] = '{16'h0001, 16'h0100, 16'h0101, 16'h0003, 16'h0302};
	logic [ADDR_W-1:0] bad [3] = '{7'h60, 7'h09, 7'h7C};
	int num_errors = 0;
	int checked = 0;
	integer seed = 32'h0C5DA089;

	dxc_ctrl #(.MS_CYCLES(MSC)) dxc_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .gpio_inc(gpio_inc), .gpio_dec(gpio_dec), .phase_error(phase_error),
		.ref_sel(ref_sel), .frequency_word(frequency_word), .divider_bypass(divider_bypass),
		.filter_drive(filter_drive), .snap_offset(snap_offset), .snap_strobe(snap_strobe),
		.holdover(holdover), .lock_int(lock_int), .lock(lock));
	dxc_host dxc_host_inst (.aclk(aclk), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));

	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// -----------------------------------------------------------------
	// checking helpers
	// -----------------------------------------------------------------
	task automatic chk_v(input logic [63:0] g, input logic [63:0] e);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask

	task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error at %0t: response %0h expected %0h", $time, g, e);
		end
	endtask

	task automatic ended(input string s);
		$display("test %0s ended at %0t", s, $time);
	endtask

	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// steps clamp at the word limits rather than wrapping
	function automatic logic [FW_W-1:0] sat(input logic [FW_W-1:0] f, input logic [31:0] s,
		input logic dn);
		logic signed [63:0] t;
		t = {{22{f[FW_W-1]}}, f};
		t = dn ? t - {32'h0, s} : t + {32'h0, s};
		if (t > $signed({22'h0, FW_MAX}))
			t = {22'h0, FW_MAX};
		if (t < $signed({22'h3F_FFFF, FW_MIN}))
			t = {22'h3F_FFFF, FW_MIN};
		return t[FW_W-1:0];
	endfunction

	task automatic w(input logic [ADDR_W-1:0] a, input logic [31:0] x);
		logic [1:0] q;
		dxc_host_inst.wr(a, x, q);
		chk_r(q, RESP_OKAY);
	endtask

	task automatic set_fw(input int o, input logic [FW_W-1:0] f);
		logic [47:0] x;
		x = dxc_host_inst.sx(f);
		w(o ? OFS_FREQ_LO1 : OFS_FREQ_LO0, x[31:0]);
		repeat (3) @(posedge aclk);
		chk_v(frequency_word[o], fw[o]);
		w(o ? OFS_FREQ_HI1 : OFS_FREQ_HI0, {16'h0000, x[47:32]});
		repeat (3) @(posedge aclk);
		fw[o] = f;
		chk_v(frequency_word[0], fw[0]);
		chk_v(frequency_word[1], fw[1]);
	endtask

	task automatic step(input logic [15:0] c);
		w(OFS_STEP_CMD, {16'h0000, c});
		for (int k = 0; k < NOSC; k++)
			if (c[k] != c[CMD_DEC_LSB+k])
				fw[k] = sat(fw[k], stp[k], c[CMD_DEC_LSB+k]);
		repeat (2) @(posedge aclk);
		chk_v(frequency_word[0], fw[0]);
		chk_v(frequency_word[1], fw[1]);
	endtask

	initial
	begin
		#100000;
		num_errors++;
		$display("Error at %0t: watchdog got %0h expected %0h", $time, 1'b1, 1'b0);
		finish_test;
	end

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial
	begin
		{aresetn, gpio_inc, gpio_dec} = 3'h0;
		phase_error = 32'h0;
		ref_sel = 2'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_v(divider_bypass, 1'b1);
		chk_v(frequency_word[0], 42'h0);
		dxc_host_inst.rd(OFS_CTRL, d, r);
		chk_v(d, CTRL_RST);
		ended("reset");
		for (int i = 0; i < 6; i++)
		begin
			rr = {$random(seed), $random(seed)};
			set_fw(i % 2, i < 2 ? (i ? FW_MIN : FW_MAX) : rr[FW_W-1:0]);
		end
		set_fw(1, dxc_host_inst.ppm_word(-12.5));
		ended("frequency");
		stp[0] = $random(seed);
		stp[1] = $random(seed);
		w(OFS_STEP0, stp[0]);
		w(OFS_STEP1, stp[1]);
		for (int i = 0; i < 5; i++)
			step(cmds[i]);
		set_fw(0, FW_MAX - 42'h1);
		set_fw(1, FW_MIN + 42'h1);
		stp[0] = 32'h5;
		stp[1] = 32'h5;
		w(OFS_STEP0, stp[0]);
		w(OFS_STEP1, stp[1]);
		step(16'h0201);
		step(16'h0201);
		ended("step");
		// pin pulses follow the 64 ns link period; the last two run with pins disabled
		for (int i = 0; i < 6; i++)
		begin
			if (i == 0 || i == 4)
				w(OFS_CTRL, i ? 32'h0 : 32'h60);
			v = $random(seed);
			gpio_inc <= v[0];
			gpio_dec <= !v[0];
			repeat (8) @(posedge aclk);
			gpio_inc <= 1'b0;
			gpio_dec <= 1'b0;
			repeat (8) @(posedge aclk);
			if (i < 4)
				fw[1] = sat(fw[1], stp[1], !v[0]);
			chk_v(frequency_word[1], fw[1]);
		end
		ended("pins");
		w(OFS_CTRL, 32'h1);
		p = $random(seed);
		w(OFS_PHASE, p);
		repeat (3) @(posedge aclk);
		chk_v(filter_drive, p);
		chk_v(divider_bypass, 1'b0);
		w(OFS_PTIMER, 32'h2);
		for (int m = 0; m < 2; m++)
		begin
			w(OFS_CTRL, m ? 32'hD : 32'h5);
			p = $random(seed);
			w(OFS_PHASE, p);
			repeat (40) @(posedge aclk);
			chk_v(filter_drive, p);
			repeat (120) @(posedge aclk);
			dxc_host_inst.rd(OFS_STATUS, d, r);
			chk_v(d[3:2], {1'b0, m[0]});
			if (m == 0)
				chk_v(filter_drive, 32'h0);
			else
				chk_v(holdover, 1'b1);
		end
		w(OFS_PHASE, 32'h0);
		repeat (2) @(posedge aclk);
		chk_v(holdover, 1'b0);
		// widest cap: budget never runs dry, so the target moves one step a clock
		w(OFS_CTRL, 32'h11);
		w(OFS_SLOPE, 32'hFFFF);
		repeat (100) @(posedge aclk);
		w(OFS_PHASE, 32'h10);
		repeat (4) @(posedge aclk);
		chk_v(filter_drive, 32'h4);
		ended("phase");
		w(OFS_CTRL, 32'h2);
		choff = $random(seed) % 4096;
		w(OFS_CH_OFF, choff);
		for (int k = 0; k < NIN; k++)
		begin
			inoff[k] = $random(seed) % 4096;
			w(ADDR_W'(OFS_IN_OFF0 + 4 * k), inoff[k]);
		end
		phase_error <= $random(seed) % 4096;
		for (int i = 0; i < NIN; i++)
		begin
			ref_sel <= 2'(i * 3);
			repeat (4) @(posedge aclk);
			d = inoff[(i * 3) % NIN] + choff;
			chk_v(snap_offset, d);
			chk_v(filter_drive, 32'(phase_error + d));
		end
		ended("closed");
		phase_error <= 32'h3E8;
		w(OFS_LOCK_WIN, 32'h64);
		w(OFS_LOCK_TIME, 32'h4);
		repeat (4) @(posedge aclk);
		chk_v(lock, 1'b0);
		phase_error <= ($random(seed) % 2) ? 32'hFFFF_FFF6 : 32'hA;
		repeat (50) @(posedge aclk);
		chk_v(lock_int, 1'b0);
		repeat (100) @(posedge aclk);
		chk_v(lock_int, 1'b1);
		chk_v(lock, 1'b0);
		repeat (150) @(posedge aclk);
		chk_v(lock, 1'b1);
		phase_error <= 32'h3E8;
		repeat (4) @(posedge aclk);
		chk_v(lock, 1'b0);
		ended("lock");
		for (int i = 0; i < 3; i++)
		begin
			dxc_host_inst.wr(bad[i], 32'hFFFF_FFFF, r);
			chk_r(r, RESP_SLVERR);
			dxc_host_inst.rd(bad[i], d, r);
			chk_r(r, RESP_SLVERR);
			chk_v(d, 32'h0);
		end
		dxc_host_inst.rd(OFS_CH_OFF, d, r);
		chk_v(d, choff);
		ended("bus");
		finish_test;
	end
endmodule

bind dxc_ctrl dxc_ctrl_assertions dxc_ctrl_assertions_inst (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
	.wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
	.ref_sel(ref_sel), .frequency_word(frequency_word), .snap_strobe(snap_strobe),
	.lock_int(lock_int), .lock(lock));

//--- sim/dxc_host.sv
// axi4-lite master model standing in for the steering controller
`timescale 1ns/100ps
module dxc_host
	import dxc_pkg::*;
(
	// clock
	input wire logic aclk,
	// write side
	output logic awvalid,
	input wire logic awready,
	output logic [ADDR_W-1:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	// read side
	output logic arvalid,
	input wire logic arready,
	output logic [ADDR_W-1:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 7'h00;
		araddr = 7'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
	end

	// the 42-bit word travels sign-extended across the 48-bit register pair
	function automatic logic [47:0] sx(input logic [FW_W-1:0] f);
		return {{6{f[FW_W-1]}}, f};
	endfunction

	// steering word for an offset in ppm, scaled by two to the 53rd
	function automatic logic [FW_W-1:0] ppm_word(input real ppm);
		real x;
		x = (1.0 - 1.0 / (1.0 + ppm / 1.0e6)) * 9007199254740992.0;
		return FW_W'(longint'(x));
	endfunction

	// released payload is inverted so a stale value never passes for a live one
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
		logic fin;
		fin = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!fin)
		begin
			@(posedge aclk);
			if (awvalid && awready)
			begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready)
			begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			// ready follows valid by a cycle, so the slave must hold its answer
			if (bvalid && bready)
			begin
				fin = 1'b1;
				bready <= 1'b0;
				r = bresp;
			end
			else if (bvalid)
				bready <= 1'b1;
		end
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		logic fin;
		fin = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		while (!fin)
		begin
			@(posedge aclk);
			if (arvalid && arready)
			begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid && rready)
			begin
				fin = 1'b1;
				rready <= 1'b0;
				d = rdata;
				r = rresp;
			end
			else if (rvalid)
				rready <= 1'b1;
		end
	endtask
endmodule
